// [hw/sar_adc_pkg.sv]
// Constants for the SAR converter sequencer
package sar_adc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // Command port offsets
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] CFG_OFF = 4'h1;
  localparam logic [3:0] RES_OFF = 4'h2;
  localparam logic [3:0] STAT_OFF = 4'h3;
  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_BURST_BIT = 6;
  localparam int CTRL_LJ_BIT = 2;
  localparam int CTRL_SRC_LO = 0;
  // Configuration register fields
  localparam int CFG_DIV_LO = 0;
  localparam int CFG_TM_LO = 5;
  localparam int CFG_TK_LO = 8;
  localparam int CFG_PWR_LO = 12;
  localparam int CFG_RPT_LO = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
  // Start sources
  localparam logic [1:0] SRC_SOFT = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_TMR1 = 2'h2;
  localparam logic [1:0] SRC_TMR2 = 2'h3;
  // Tracking modes
  localparam logic [1:0] TM_PRE = 2'h2;
  localparam logic [1:0] TM_POST = 2'h1;
  localparam logic [1:0] TM_DUAL = 2'h3;
  // Timing counts
  localparam int unsigned SAR_BITS = 13;
  localparam int unsigned EXTRA_CYC = 2;
  localparam int unsigned TRACK_EXTRA = 2;
  localparam int unsigned PWRUP_UNIT = 16;
endpackage

// [hw/sar_adc_sequencer.sv]
// Control sequencer of a 12-bit SAR converter
//
// Functional notes
// - One of four start sources, chosen by src_sel.
// - Writing busy bit starts conversion; it reads one until done, but zero during burst power-up.
// - Busy falling at series end sets conversion done flag and interrupt request.
// - External pin rising edge starts conversion when selected.
// - Timer two: low overflows in 8-bit, high overflows in 16-bit.
// - Enabled while power-on bit set or burst running; else shutdown.
// - Pre-tracking converts at once outside burst, tracks whenever idle with power-on bit set.
// - Post-tracking tracks after start, then input disconnected.
// - Dual-tracking tracks after start and continuously after while power-on bit set.
// - Hardware tracking lasts tracking field plus two clocks.
// - Conversion is 13 SAR clocks plus two extra clocks.
// - Subsystem clock is system clock unless burst enabled.
// - SAR clock is subsystem clock divided by divider field plus one.
// - Burst wakes, accumulates 1/4/8/16 samples, sleeps again.
// - In burst, power-on bit picks idle power state.
// - Powered-down burst start waits power-up time first.
// - Burst runs repeat-count conversions per start.
// - Done flag and window compare only after repeat count.
// - Single sample result 12-bit, justified per justify bit.
// - Repeat above one gives right-justified unsigned sum.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic external_start_pin,
  input wire logic tmr1_ovf,
  input wire logic tmr2_lo_ovf,
  input wire logic tmr2_hi_ovf,
  input wire logic tmr2_16bit,
  input wire logic burst_clk_tick,
  input wire logic [11:0] sample_code,
  output logic converter_powered,
  output logic track_switch,
  output logic sar_step,
  output logic window_compare,
  output logic conv_irq
);
  import sar_adc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PWRUP = 5'b00010,
    ST_TRACK = 5'b00100,
    ST_CONV = 5'b01000,
    ST_DONE = 5'b10000
  } state_t;

  state_t state_q, state_d;
  logic [31:0] ctrl_q, cfg_q;
  logic [15:0] result_q, acc_q;
  logic [7:0] cnt_q;
  logic [7:0] div_q;
  logic [4:0] rep_q;
  logic pin_s1_q, pin_s2_q, pin_prev_q;
  logic irq_q, wcmp_q;
  logic overrun_q;
  logic [31:0] rd_mux;

  wire en_bit = ctrl_q[CTRL_EN_BIT];
  wire burst_bit = ctrl_q[CTRL_BURST_BIT];
  wire lj_bit = ctrl_q[CTRL_LJ_BIT];
  wire [1:0] src_sel = ctrl_q[CTRL_SRC_LO +: 2];
  wire [7:0] div_sel = {3'h0, cfg_q[CFG_DIV_LO +: 5]};
  wire [1:0] tm_sel = cfg_q[CFG_TM_LO +: 2];
  wire [3:0] tk_sel = cfg_q[CFG_TK_LO +: 4];
  wire [3:0] pwr_sel = cfg_q[CFG_PWR_LO +: 4];
  wire [1:0] rpt_sel = cfg_q[CFG_RPT_LO +: 2];

  wire wr_ctrl = wr_stb && addr == CTRL_OFF;
  wire wr_cfg = wr_stb && addr == CFG_OFF;
  wire soft_go = wr_ctrl && wdata[CTRL_BUSY_BIT];

  // Burst oscillator tick paces the subsystem
  wire subsystem_clock_tick = burst_bit ? burst_clk_tick : 1'b1;

  // Rising edge of the synchronised pin
  wire pin_rise = pin_s2_q && !pin_prev_q;
  // Timer two overflow width follows its mode
  wire tmr2_ovf = tmr2_16bit ? tmr2_hi_ovf : tmr2_lo_ovf;
  // One lane per start source, only the selected one passes
  wire [3:0] src_event = {tmr2_ovf, tmr1_ovf, pin_rise, soft_go};
  wire [3:0] src_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
      assign src_hit[gi] = src_event[gi] && (src_sel == 2'(gi));
    end
  endgenerate
  wire start_req = |src_hit;
  // A start that lands while a sequence runs is dropped, but noted
  wire start_lost = start_req && state_q != ST_IDLE;

  wire [4:0] rep_total = (rpt_sel == 2'h0) ? 5'd1 :
                         (rpt_sel == 2'h1) ? 5'd4 :
                         (rpt_sel == 2'h2) ? 5'd8 : 5'd16;
  wire last_rep = (rep_q + 5'd1) >= rep_total;

  // Conversion: one head clock, the SAR bits, one tail clock
  wire [7:0] conv_last = 8'(SAR_BITS) + 8'(EXTRA_CYC) - 8'h01;
  wire conv_head = state_q == ST_CONV && cnt_q == 8'h00;
  wire conv_tail = state_q == ST_CONV && cnt_q == conv_last;
  wire sar_phase = state_q == ST_CONV && !conv_head && !conv_tail;

  // SAR clock tick from divided subsystem clock
  wire sar_tick = sar_phase && subsystem_clock_tick && div_q == div_sel;
  wire [7:0] track_len = {4'h0, tk_sel} + 8'(TRACK_EXTRA);
  wire [7:0] pwr_len = 8'({4'h0, pwr_sel}) * 8'(PWRUP_UNIT);
  wire hw_track = tm_sel != TM_PRE;

  // Counter advance: SUBSYSTEM_CLOCK outside the SAR phase, SAR clock inside it
  wire cnt_step = sar_phase ? sar_tick : subsystem_clock_tick;
  wire state_move = state_d != state_q;

  // Enabled while power-on bit set or burst work active
  wire active = state_q != ST_IDLE;
  // In burst the power-on bit only sets the idle state
  wire burst_awake = burst_bit && active;
  assign converter_powered = en_bit || burst_awake;

  // Pre-tracking follows the input whenever idle with the power-on bit set
  wire idle_track_pre = tm_sel == TM_PRE;
  // Dual-tracking also follows the input between conversions
  wire idle_track_dual = tm_sel == TM_DUAL;
  // Post-tracking leaves the input open while idle
  wire idle_track = en_bit && (idle_track_pre || idle_track_dual);
  assign track_switch = (state_q == ST_TRACK) ||
                        (state_q == ST_IDLE && idle_track);
  assign sar_step = sar_tick;
  assign window_compare = wcmp_q;
  assign conv_irq = irq_q;

  wire [15:0] sum_next = acc_q + {4'h0, sample_code};
  wire [15:0] single_res = lj_bit ? {sample_code, 4'h0} :
                                    {4'h0, sample_code};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_req && (en_bit || !burst_bit))
          state_d = hw_track ? ST_TRACK : ST_CONV;
        else if (start_req && burst_bit)
          state_d = ST_PWRUP;
      end
      ST_PWRUP: begin
        if (subsystem_clock_tick && cnt_q >= pwr_len)
          state_d = ST_TRACK;
      end
      ST_TRACK: begin
        if (subsystem_clock_tick && cnt_q + 8'h01 >= track_len)
          state_d = ST_CONV;
      end
      ST_CONV: begin
        if (conv_tail && subsystem_clock_tick)
          state_d = ST_DONE;
      end
      ST_DONE: begin
        // Burst continues the series on its own
        if (burst_bit && !last_rep)
          state_d = ST_TRACK;
        else
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Two-stage synchroniser for the asynchronous pin
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else if (clk_en) begin
      pin_s1_q <= external_start_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Edge history resets to the pin's idle level: no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_q <= 1'b0;
    end else if (clk_en) begin
      pin_prev_q <= pin_s2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Phase counter restarts on every state change
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (state_move)
        cnt_q <= 8'h00;
      else if (cnt_step)
        cnt_q <= cnt_q + 8'h01;
    end
  end

  // Divider only runs inside the SAR phase
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 8'h00;
    end else if (clk_en) begin
      if (!sar_phase || sar_tick)
        div_q <= 8'h00;
      else if (subsystem_clock_tick)
        div_q <= div_q + 8'h01;
    end
  end

  // Only the first start of a series clears the sums
  wire series_open = state_q == ST_IDLE && state_d != ST_IDLE &&
                     rep_q == 5'h00;
  wire sample_take = state_q == ST_DONE;
  wire series_end = sample_take && last_rep;

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= 16'h0000;
    end else if (clk_en) begin
      if (series_open || series_end)
        acc_q <= 16'h0000;
      else if (sample_take)
        acc_q <= sum_next;
    end
  end

  // Repeat counter walks the series, in normal mode too
  always_ff @(posedge clk) begin
    if (rst) begin
      rep_q <= 5'h00;
    end else if (clk_en) begin
      if (series_open || series_end)
        rep_q <= 5'h00;
      else if (sample_take)
        rep_q <= rep_q + 5'h01;
    end
  end

  // Result and compare only after full series
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= 16'h0000;
    end else if (clk_en && series_end) begin
      result_q <= (rep_total == 5'd1) ? single_res : sum_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wcmp_q <= 1'b0;
    end else if (clk_en) begin
      wcmp_q <= series_end;
    end
  end

  wire [31:0] ctrl_wr = wdata & ~(32'h1 << CTRL_BUSY_BIT);
  // Busy holds through a burst series, power-up excluded
  wire busy_next = (state_d != ST_IDLE && state_d != ST_PWRUP) ||
                   (sample_take && !series_end);

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= CFG_RESET;
    end else if (clk_en && wr_cfg) begin
      cfg_q <= wdata;
    end
  end

  // Set wins over a simultaneous software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (clk_en) begin
      if (wr_ctrl)
        ctrl_q <= ctrl_wr;
      ctrl_q[CTRL_BUSY_BIT] <= busy_next;
      if (series_end)
        ctrl_q[CTRL_DONE_BIT] <= 1'b1;
    end
  end

  // Done pulse beside the flag; interrupt enable lives outside
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= series_end;
    end
  end

  // Dropped start is sticky until the next control write
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (clk_en) begin
      if (start_lost)
        overrun_q <= 1'b1;
      else if (wr_ctrl)
        overrun_q <= 1'b0;
    end
  end

  wire [31:0] res_word = {16'h0000, result_q};
  wire [31:0] stat_word = {10'h000, overrun_q, rep_q, cnt_q, 3'h0, state_q};
  wire sel_ctrl = addr == CTRL_OFF;
  wire sel_cfg = addr == CFG_OFF;
  wire sel_res = addr == RES_OFF;
  wire sel_stat = addr == STAT_OFF;
  // Unmapped words fall through to zero
  assign rd_mux = ({32{sel_ctrl}} & ctrl_q) |
                  ({32{sel_cfg}} & cfg_q) |
                  ({32{sel_res}} & res_word) |
                  ({32{sel_stat}} & stat_word);

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (clk_en) begin
      rdata <= rd_stb ? rd_mux : 32'h0;
    end
  end
endmodule
`default_nettype wire

// [bench/burst_osc_model.sv]
// Burst oscillator model at the sequencer's far side
`timescale 1ns/1ns
`default_nettype none
module burst_osc_model (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
    end
  end
endmodule
`default_nettype wire

// [bench/sar_adc_sequencer_checker.sv]
// Port assertions for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_adc_sequencer_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic converter_powered,
  input wire logic track_switch,
  input wire logic sar_step,
  input wire logic window_compare,
  input wire logic conv_irq
);
  import sar_adc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_irq_with_window: assert property (conv_irq |-> window_compare)
    else $error("done without window compare");
  chk_window_one_cycle: assert property (window_compare && clk_en |=> !window_compare)
    else $error("window pulse too long");
  chk_irq_one_cycle: assert property (conv_irq && clk_en |=> !conv_irq)
    else $error("done pulse too long");
  chk_rdata_idle_zero: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data outside slot");
  chk_enable_powers: assert property (wr_stb && clk_en && addr == CTRL_OFF
    && wdata[CTRL_EN_BIT] |=> converter_powered)
    else $error("enable did not power");
  chk_step_powered: assert property (sar_step |-> converter_powered)
    else $error("converting while shut down");
  chk_step_no_track: assert property (sar_step |-> !track_switch)
    else $error("tracking during conversion");
  // Frozen state must not move the done pulse
  chk_freeze_holds: assert property (!clk_en |=> $stable(conv_irq))
    else $error("done moved while frozen");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_checker chk (.clk, .rst, .clk_en,
  .addr, .wdata, .wr_stb, .rd_stb, .rdata, .converter_powered,
  .track_switch, .sar_step, .window_compare, .conv_irq);
`default_nettype wire

// [bench/test_sar_adc_sequencer.sv]
// Directed testbench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_sequencer;
  import sar_adc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic t16 = 1'b0, tick, powered, trk, step, win, irq;
  logic [3:0] trig = 4'h0, addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [11:0] code = 12'hABC;
  int error_cnt = 0, checks = 0, n, steps;
  initial forever #10 clk = ~clk;
  burst_osc_model osc (.clk, .rst, .tick);
  sar_adc_sequencer uut (.clk, .rst, .clk_en, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .external_start_pin(trig[3]), .tmr1_ovf(trig[0]),
    .tmr2_lo_ovf(trig[1]), .tmr2_hi_ovf(trig[2]), .tmr2_16bit(t16),
    .burst_clk_tick(tick), .sample_code(code), .converter_powered(powered),
    .track_switch(trk), .sar_step(step), .window_compare(win),
    .conv_irq(irq));
  task automatic close_out;
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 got = rdata;
  endtask
  // Counts done pulses; a series must give exactly one
  task automatic run(input int cyc);
    n = 0;
    steps = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1 if (irq === 1'b1) n++;
      if (step === 1'b1) steps++;
    end
  endtask
  task automatic fire(input int b, input int want);
    @(posedge clk);
    trig[b] <= 1'b1;
    @(posedge clk);
    trig <= 4'h0;
    run(400);
    cmp(n, want);
  endtask
  initial begin
    #400000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_OFF); cmp(got, CTRL_RESET);
    rd(CFG_OFF); cmp(got, CFG_RESET);
    rd(4'hF); cmp(got, 32'h0);
    wr(CFG_OFF, 32'h0000_0121);
    wr(CTRL_OFF, 32'h0000_0090);
    rd(CTRL_OFF); cmp(got[4], 1'b1);
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    run(400); cmp(n, 1);
    cmp(trk, 1'b0);
    rd(CTRL_OFF); cmp(got[5:4], 2'b10);
    rd(RES_OFF); cmp(got, 32'h0000_0ABC);
    wr(CTRL_OFF, 32'h0000_0094);
    run(400); cmp(n, 1);
    cmp(steps, SAR_BITS);
    rd(RES_OFF); cmp(got, 32'h0000_ABC0);
    wr(CTRL_OFF, 32'h0000_0081);
    fire(0, 0);
    fire(3, 1);
    wr(CTRL_OFF, 32'h0000_0082);
    fire(0, 1);
    wr(CTRL_OFF, 32'h0000_0083);
    for (int m = 0; m < 2; m++) begin
      t16 <= m[0];
      fire(1, m == 0);
      fire(2, m == 1);
    end
    // Pre-tracking in normal mode
    wr(CFG_OFF, 32'h0000_0141);
    wr(CTRL_OFF, 32'h0000_0080);
    // software leaves the tracking time before the start
    repeat (20) @(posedge clk);
    #1 cmp(trk, 1'b1);
    wr(CTRL_OFF, 32'h0000_0090);
    run(400); cmp(n, 1);
    cmp(steps, SAR_BITS);
    cmp(trk, 1'b1);
    // Burst series from power-down, 4, 8 and 16 samples
    // burst runs use dual tracking; one start per series
    for (int r = 1; r < 4; r++) begin
      wr(CFG_OFF, 32'h0000_0161 | (r << CFG_RPT_LO));
      wr(CTRL_OFF, 32'h0000_0040);
      wr(CTRL_OFF, 32'h0000_0050);
      run(1500); cmp(n, 1);
      cmp(steps, SAR_BITS << (r + 1));
      rd(RES_OFF); cmp(got, 32'h0000_0ABC << (r + 1));
      cmp(powered, 1'b0);
    end
    close_out;
  end
endmodule
`default_nettype wire
